// ===== rtl/dio_diag_defs.vh
// register offsets, field positions and reset values of the digital io diagnostic bank
`ifndef DIO_DIAG_DEFS_VH
`define DIO_DIAG_DEFS_VH

// parameter addresses as printed, 16-bit word parameters
`define ADDR_SOFT_OUTPUT_FORCE     16'h050c
`define ADDR_INPUT_STATE_FORCE     16'h050e
`define ADDR_KEYPAD_KEY_STATUS     16'h0510
`define ADDR_OUTPUT_STATE          16'h0512
`define ADDR_ERROR_HISTORY_CLEAR   16'h0514

// widths
`define DATA_W                     16
`define NUM_DIN                    8
`define NUM_DOUT                   4
`define NUM_KEYS                   5
`define NUM_SOFT_FN                4
`define FUNC_W                     4

// soft output function codes as held in the output function selection
`define FUNC_SOFT_OUTPUT_0         4'h0
`define FUNC_SOFT_OUTPUT_1         4'h1
`define FUNC_SOFT_OUTPUT_2         4'h2
`define FUNC_SOFT_OUTPUT_3         4'h3

// keypad status bit positions
`define KEY_SET_BIT                0
`define KEY_MODE_BIT               1
`define KEY_UP_BIT                 2
`define KEY_DOWN_BIT               3
`define KEY_ENTER_BIT              4

// output state bit positions
`define OUT_RESERVED_BIT           4
`define OUT_ENC_ZERO_BIT           5

// reset values
`define RST_SOFT_OUTPUT_FORCE      16'h0000
`define RST_INPUT_FORCE            8'h00
`define RST_ERROR_HISTORY_CLEAR    16'h0000
`define RST_DATA                   16'h0000

// value that, written to the clear parameter, wipes the error history
`define ERROR_HISTORY_CLEAR_CODE   16'h0000

`endif

// ===== rtl/pin_sync.v
// two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,      // system clock
  input  wire             i_reset_n,  // synchronous reset, active low
  input  wire [WIDTH-1:0] i_async,    // asynchronous pin levels
  output reg  [WIDTH-1:0] o_sync      // levels after two flip-flops
);

  reg [WIDTH-1:0] meta_r;

  // the first stage is read only by the second stage
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_r <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ===== rtl/digital_io_diagnostic_regs.v
// diagnostic parameter bank for digital inputs, keypad, digital outputs and error history clear
`timescale 1ns/1ps
`include "dio_diag_defs.vh"

// How it works
// - soft force bits 2 and 3 drive outputs assigned soft functions two and three
// - reading input state gives each input level, input k at bit k-1
// - writing input state overrides an input only when its permission bit is 1
// - a permitted input takes the written bit regardless of its previous level
// - keypad status shows one bit per key, one while held down
// - keypad bits: set 0, mode 1, up 2, down 3, enter 4
// - output state bits 0 to 3 are one while outputs one to four are active
// - output state bit 4 reserved, bit 5 shows encoder zero pulse output
// - writing zero to the error history clear parameter erases the error history
module digital_io_diagnostic_regs (
  input  wire                              i_clk,              // 40 MHz system clock
  input  wire                              i_reset_n,          // synchronous reset, active low
  input  wire [15:0]                       i_par_addr,         // parameter address
  input  wire                              i_par_wr,           // write strobe, one cycle
  input  wire                              i_par_rd,           // read strobe, one cycle
  input  wire [`DATA_W-1:0]                i_par_wdata,        // write data
  output reg  [`DATA_W-1:0]                o_par_rdata,        // read data, valid with ack
  output reg                               o_par_ack,          // access done, one cycle
  output reg                               o_par_err,          // unmapped or read-only write
  input  wire [`NUM_DIN-1:0]               i_din_pin,          // digital input pins, async
  input  wire [`NUM_DIN-1:0]               i_input_force_permission_mask, // per input
  output reg  [`NUM_DIN-1:0]               o_din_logic,        // logical input levels
  input  wire [`NUM_KEYS-1:0]              i_key_pin,          // keypad keys, 1 = pressed
  input  wire [`NUM_DOUT-1:0]              i_dout_logic,       // output levels from drive logic
  input  wire [`NUM_DOUT*`FUNC_W-1:0]      i_dout_func,        // function code per output
  input  wire                              i_enc_zero_pulse,   // encoder zero pulse, same clock
  output reg  [`NUM_DOUT-1:0]              o_dout,             // digital outputs one to four
  output reg                               o_enc_zero_pulse_output, // zero pulse output
  output reg                               o_error_history_clear    // clear pulse, one cycle
);

  // pin synchronisation
  // keys are not debounced: the keypad word shows the raw synchronised level
  wire [`NUM_DIN-1:0]  din_sync;
  wire [`NUM_KEYS-1:0] key_sync;

  pin_sync #(
    .WIDTH (`NUM_DIN)
  ) u_din_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_din_pin),
    .o_sync    (din_sync)
  );

  pin_sync #(
    .WIDTH (`NUM_KEYS)
  ) u_key_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_key_pin),
    .o_sync    (key_sync)
  );

  // address decode
  wire hit_soft   = (i_par_addr == `ADDR_SOFT_OUTPUT_FORCE);
  wire hit_input  = (i_par_addr == `ADDR_INPUT_STATE_FORCE);
  wire hit_keypad = (i_par_addr == `ADDR_KEYPAD_KEY_STATUS);
  wire hit_output = (i_par_addr == `ADDR_OUTPUT_STATE);
  wire hit_clear  = (i_par_addr == `ADDR_ERROR_HISTORY_CLEAR);
  wire hit_any    = hit_soft | hit_input | hit_keypad | hit_output | hit_clear;
  wire hit_ro     = hit_keypad | hit_output;

  // a read and a write in the same cycle: the write is served, the read dropped
  wire wr_en      = i_par_wr;
  wire rd_en      = i_par_rd & ~i_par_wr;
  wire wr_soft    = wr_en & hit_soft;
  wire wr_input   = wr_en & hit_input;
  wire wr_clear   = wr_en & hit_clear;

  // refused: unmapped word, or a write to one of the two read-only words
  wire wr_refused = wr_en & (~hit_any | hit_ro);
  wire rd_refused = rd_en & ~hit_any;

  // writable registers
  reg  [`DATA_W-1:0]  soft_output_force_r;
  reg  [`DATA_W-1:0]  soft_output_force_nxt;
  reg  [`NUM_DIN-1:0] force_value_r;
  reg  [`NUM_DIN-1:0] force_value_nxt;
  reg  [`NUM_DIN-1:0] forced_r;
  reg  [`NUM_DIN-1:0] forced_nxt;
  reg  [`DATA_W-1:0]  error_history_clear_r;
  reg  [`DATA_W-1:0]  error_history_clear_nxt;
  reg                 clear_pulse_nxt;

  wire [`NUM_DIN-1:0] wr_bits = i_par_wdata[`NUM_DIN-1:0];

  // soft output forcing word
  always @* begin
    soft_output_force_nxt = soft_output_force_r;
    if (wr_soft) begin
      soft_output_force_nxt = i_par_wdata;
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      soft_output_force_r <= `RST_SOFT_OUTPUT_FORCE;
    end else begin
      soft_output_force_r <= soft_output_force_nxt;
    end
  end

  // input forcing: written level and forced mark per input
  always @* begin
    force_value_nxt = force_value_r;
    // a mark whose permission is gone is dropped, so a later grant needs a new write
    forced_nxt      = forced_r & i_input_force_permission_mask;
    if (wr_input) begin
      // only permitted inputs pick up the written level; the rest stay on their pins
      force_value_nxt = (force_value_r & ~i_input_force_permission_mask) |
                        (wr_bits & i_input_force_permission_mask);
      forced_nxt      = forced_nxt | i_input_force_permission_mask;
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      force_value_r <= `RST_INPUT_FORCE;
      forced_r      <= `RST_INPUT_FORCE;
    end else begin
      force_value_r <= force_value_nxt;
      forced_r      <= forced_nxt;
    end
  end

  // error history clear: the word reads back, a zero fires the erase pulse
  always @* begin
    error_history_clear_nxt = error_history_clear_r;
    clear_pulse_nxt         = 1'b0;
    if (wr_clear) begin
      error_history_clear_nxt = i_par_wdata;
      if (i_par_wdata == `ERROR_HISTORY_CLEAR_CODE) begin
        clear_pulse_nxt = 1'b1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      error_history_clear_r <= `RST_ERROR_HISTORY_CLEAR;
      o_error_history_clear <= 1'b0;
    end else begin
      error_history_clear_r <= error_history_clear_nxt;
      o_error_history_clear <= clear_pulse_nxt;
    end
  end

  // logical input levels
  wire [`NUM_DIN-1:0] din_nxt;

  genvar d;
  generate
    for (d = 0; d < `NUM_DIN; d = d + 1) begin : g_din
      // withdrawing permission drops the force at once, the pin takes over
      wire use_force = forced_r[d] & i_input_force_permission_mask[d];
      assign din_nxt[d] = use_force ? force_value_r[d] : din_sync[d];
    end
  endgenerate

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_din_logic <= {`NUM_DIN{1'b0}};
    end else begin
      o_din_logic <= din_nxt;
    end
  end

  // digital outputs with soft function forcing
  wire [`NUM_DOUT-1:0] dout_nxt;

  genvar g;
  generate
    for (g = 0; g < `NUM_DOUT; g = g + 1) begin : g_dout
      wire [`FUNC_W-1:0] func = i_dout_func[g*`FUNC_W +: `FUNC_W];
      reg                soft_set;
      // several outputs may share one soft function; each follows the same bit
      always @* begin
        case (func)
          `FUNC_SOFT_OUTPUT_0: begin
            soft_set = soft_output_force_r[0];
          end
          `FUNC_SOFT_OUTPUT_1: begin
            soft_set = soft_output_force_r[1];
          end
          `FUNC_SOFT_OUTPUT_2: begin
            soft_set = soft_output_force_r[2];
          end
          `FUNC_SOFT_OUTPUT_3: begin
            soft_set = soft_output_force_r[3];
          end
          // other codes are not soft functions and never force the output
          default: begin
            soft_set = 1'b0;
          end
        endcase
      end
      assign dout_nxt[g] = i_dout_logic[g] | soft_set;
    end
  endgenerate

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_dout <= {`NUM_DOUT{1'b0}};
    end else begin
      o_dout <= dout_nxt;
    end
  end

  // the zero pulse comes from logic on this clock, so it needs no synchroniser
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_enc_zero_pulse_output <= 1'b0;
    end else begin
      o_enc_zero_pulse_output <= i_enc_zero_pulse;
    end
  end

  // read-only status words; their unused upper bits read zero
  reg [`DATA_W-1:0] keypad_word;
  reg [`DATA_W-1:0] output_word;

  always @* begin
    keypad_word                 = `RST_DATA;
    keypad_word[`KEY_SET_BIT]   = key_sync[`KEY_SET_BIT];
    keypad_word[`KEY_MODE_BIT]  = key_sync[`KEY_MODE_BIT];
    keypad_word[`KEY_UP_BIT]    = key_sync[`KEY_UP_BIT];
    keypad_word[`KEY_DOWN_BIT]  = key_sync[`KEY_DOWN_BIT];
    keypad_word[`KEY_ENTER_BIT] = key_sync[`KEY_ENTER_BIT];
  end

  always @* begin
    output_word                    = `RST_DATA;
    // reports what is on the pins, forcing included
    output_word[`NUM_DOUT-1:0]     = o_dout;
    output_word[`OUT_RESERVED_BIT] = 1'b0;
    output_word[`OUT_ENC_ZERO_BIT] = o_enc_zero_pulse_output;
  end

  // read mux and answer
  reg [`DATA_W-1:0] rdata_nxt;

  always @* begin
    rdata_nxt = `RST_DATA;
    case (i_par_addr)
      `ADDR_SOFT_OUTPUT_FORCE: begin
        rdata_nxt = soft_output_force_r;
      end
      `ADDR_INPUT_STATE_FORCE: begin
        rdata_nxt = {{(`DATA_W-`NUM_DIN){1'b0}}, o_din_logic};
      end
      `ADDR_KEYPAD_KEY_STATUS: begin
        rdata_nxt = keypad_word;
      end
      `ADDR_OUTPUT_STATE: begin
        rdata_nxt = output_word;
      end
      `ADDR_ERROR_HISTORY_CLEAR: begin
        rdata_nxt = error_history_clear_r;
      end
      default: begin
        rdata_nxt = `RST_DATA;
      end
    endcase
  end

  // every accepted strobe is answered one cycle later, refused ones included
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_par_ack <= 1'b0;
    end else begin
      o_par_ack <= wr_en | rd_en;
    end
  end

  // the error flag stands with the ack of the refused access
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_par_err <= 1'b0;
    end else begin
      o_par_err <= wr_refused | rd_refused;
    end
  end

  // read data stands only in the answer cycle of a read, zero otherwise
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_par_rdata <= `RST_DATA;
    end else if (rd_en) begin
      o_par_rdata <= rdata_nxt;
    end else begin
      o_par_rdata <= `RST_DATA;
    end
  end

endmodule

// ===== bench/dio_diag_properties.sv
// assertions on the ports of the digital io diagnostic bank
`timescale 1ns/1ps
`include "dio_diag_defs.vh"
module dio_diag_properties (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_par_addr,
  input wire logic        i_par_wr,
  input wire logic        i_par_rd,
  input wire logic [15:0] i_par_wdata,
  input wire logic [15:0] o_par_rdata,
  input wire logic        o_par_ack,
  input wire logic        o_par_err,
  input wire logic [7:0]  i_din_pin,
  input wire logic [7:0]  i_input_force_permission_mask,
  input wire logic [7:0]  o_din_logic,
  input wire logic [15:0] i_dout_func,
  input wire logic [3:0]  o_dout,
  input wire logic        o_enc_zero_pulse_output,
  input wire logic        o_error_history_clear
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire rd = i_par_rd && !i_par_wr;
  wire [7:0] msk = i_input_force_permission_mask;
  AST_ACK: assert property ((i_par_wr || i_par_rd) |=> o_par_ack)
    else $error("no ack after strobe");
  AST_IDLE: assert property (!(i_par_wr || i_par_rd) |=> !o_par_ack && o_par_rdata == 16'h0000)
    else $error("ack or data without strobe");
  AST_DIN_RD: assert property (rd && i_par_addr == `ADDR_INPUT_STATE_FORCE
    |=> o_par_rdata == {8'h00, $past(o_din_logic)}) else $error("input state read wrong");
  AST_DIN_PIN: assert property (msk == 8'h00 [*4] |-> o_din_logic == $past(i_din_pin, 3))
    else $error("input not following pin");
  AST_FORCE: assert property (i_par_wr && i_par_addr == `ADDR_INPUT_STATE_FORCE && msk == 8'hff
    ##1 msk == 8'hff |=> o_din_logic == $past(i_par_wdata[7:0], 2)) else $error("force not taken");
  AST_RO: assert property (i_par_wr && (i_par_addr == `ADDR_KEYPAD_KEY_STATUS
    || i_par_addr == `ADDR_OUTPUT_STATE) |=> o_par_err) else $error("read-only write accepted");
  AST_OUT_RD: assert property (rd && i_par_addr == `ADDR_OUTPUT_STATE |=> o_par_rdata ==
    {10'h000, $past(o_enc_zero_pulse_output), 1'b0, $past(o_dout)}) else $error("output state wrong");
  AST_SOFT: assert property (i_par_wr && i_par_addr == `ADDR_SOFT_OUTPUT_FORCE && i_par_wdata[2]
    && i_dout_func[3:0] == `FUNC_SOFT_OUTPUT_2 |-> ##2 o_dout[0]) else $error("soft force missing");
  AST_CLR: assert property (i_par_wr && i_par_addr == `ADDR_ERROR_HISTORY_CLEAR |=>
    o_error_history_clear == ($past(i_par_wdata) == 16'h0000)) else $error("clear pulse wrong");
endmodule

// ===== bench/param_host.sv
// host side of the parameter port: one access per call, strobe held one cycle
`timescale 1ns/1ps
module param_host (
  input  wire logic        i_clk,   // system clock
  output logic      [15:0] o_addr,  // parameter address
  output logic             o_wr,    // write strobe
  output logic             o_rd,    // read strobe
  output logic      [15:0] o_wdata  // write data
);
  initial begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = !w;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // released bus never keeps the last value, so a late sample cannot pass by luck
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// ===== bench/test_digital_io_diagnostic_regs.sv
// self-checking bench for the digital io diagnostic bank
`timescale 1ns/1ps
`include "dio_diag_defs.vh"
module test_digital_io_diagnostic_regs;
  logic        i_clk, i_reset_n, wr, rd, ack, err, enc, zp, clr;
  logic [15:0] addr, wdata, rdata, func, r;
  logic [7:0]  pins, mask, dlog, w;
  logic [4:0]  keys;
  logic [3:0]  dl, dout, exp_d;
  logic [16:0] q[$];
  int          err_total = 0, num_checks = 0, clr_seen = 0;
  digital_io_diagnostic_regs dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_par_addr(addr),
    .i_par_wr(wr), .i_par_rd(rd), .i_par_wdata(wdata), .o_par_rdata(rdata), .o_par_ack(ack),
    .o_par_err(err), .i_din_pin(pins), .i_input_force_permission_mask(mask), .o_din_logic(dlog),
    .i_key_pin(keys), .i_dout_logic(dl), .i_dout_func(func), .i_enc_zero_pulse(enc),
    .o_dout(dout), .o_enc_zero_pulse_output(zp), .o_error_history_clear(clr));
  param_host host_u (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_p(input logic [15:0] a, input logic [15:0] d, input logic e);
    q.push_back({e, 16'h0000});
    host_u.access(1'b1, a, d);
  endtask
  task automatic rd_p(input logic [15:0] a, input logic [15:0] x, input logic e);
    q.push_back({e, x});
    host_u.access(1'b0, a, 16'h0000);
  endtask
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (clr === 1'b1) clr_seen++;
    if (ack === 1'b1) chk({err, rdata}, (q.size() == 0) ? 17'h1ffff : q.pop_front());
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    err_total++;
    results();
  end
  initial begin
    i_reset_n = 1'b0;
    pins = 8'h00;
    mask = 8'h00;
    keys = 5'h00;
    dl = 4'h0;
    enc = 1'b0;
    // outputs one and four on soft function two, output two on three, output three plain
    func = {`FUNC_SOFT_OUTPUT_2, 4'h5, `FUNC_SOFT_OUTPUT_3, `FUNC_SOFT_OUTPUT_2};
    void'($urandom(89));
    repeat (10) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      pins = $urandom();
      mask = 8'h00;
      settle();
      rd_p(`ADDR_INPUT_STATE_FORCE, {8'h00, pins}, 1'b0);
      mask = (i == 0) ? 8'hff : $urandom();
      r = $urandom();
      w = r[7:0];
      wr_p(`ADDR_INPUT_STATE_FORCE, r, 1'b0);
      settle();
      rd_p(`ADDR_INPUT_STATE_FORCE, {8'h00, (pins & ~mask) | (w & mask)}, 1'b0);
    end
    for (int k = 0; k < 5; k++) begin
      keys = 5'h01 << k;
      settle();
      rd_p(`ADDR_KEYPAD_KEY_STATUS, 16'h0001 << k, 1'b0);
    end
    wr_p(`ADDR_KEYPAD_KEY_STATUS, 16'h001f, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r = $urandom();
      if (i == 0) r[10] = 1'b1;
      dl = r[3:0];
      enc = r[4];
      // later rounds give each output a random code, four meaning no soft function
      for (int n = 0; n < 4; n++) begin
        if (i > 0) func[4*n +: 4] = 4'($urandom_range(4));
        exp_d[n] = dl[n] | ((func[4*n +: 4] < 4'h4) && r[8 + func[4*n +: 4]]);
      end
      wr_p(`ADDR_SOFT_OUTPUT_FORCE, {12'h000, r[11:8]}, 1'b0);
      settle();
      chk({13'h0000, dout}, {13'h0000, exp_d});
      rd_p(`ADDR_OUTPUT_STATE, {10'h000, enc, 1'b0, exp_d}, 1'b0);
    end
    wr_p(`ADDR_OUTPUT_STATE, 16'h0000, 1'b1);
    wr_p(`ADDR_ERROR_HISTORY_CLEAR, 16'h1234, 1'b0);
    rd_p(`ADDR_ERROR_HISTORY_CLEAR, 16'h1234, 1'b0);
    wr_p(`ADDR_ERROR_HISTORY_CLEAR, `ERROR_HISTORY_CLEAR_CODE, 1'b0);
    rd_p(16'h0520, 16'h0000, 1'b1);
    settle();
    chk(17'(clr_seen), 17'h00001);
    chk(17'(q.size()), 17'h00000);
    results();
  end
endmodule
bind digital_io_diagnostic_regs dio_diag_properties chk_u (.i_clk, .i_reset_n, .i_par_addr,
  .i_par_wr, .i_par_rd, .i_par_wdata, .o_par_rdata, .o_par_ack, .o_par_err, .i_din_pin,
  .i_input_force_permission_mask, .o_din_logic, .i_dout_func, .o_dout,
  .o_enc_zero_pulse_output, .o_error_history_clear);
